// ===== rtl/dtcm_defines.vh
/*
 defines for the dual timer/counter block: register offsets, field positions,
 reset values and timing counts. assumes inclusion by bare name.
*/
`ifndef DTCM_DEFINES_VH
`define DTCM_DEFINES_VH
`define DTCM_OFF_CTRL      12'h0410
`define DTCM_OFF_XSTAT     12'h0411
`define DTCM_OFF_CNT_L0    12'h0450
`define DTCM_OFF_CNT_H0    12'h0451
`define DTCM_OFF_CNT_L1    12'h0452
`define DTCM_OFF_CNT_H1    12'h0453
`define DTCM_OFF_MODE      12'h045C
`define DTCM_OFF_RLD_L0    12'h0460
`define DTCM_OFF_RLD_H0    12'h0461
`define DTCM_OFF_RLD_L1    12'h0462
`define DTCM_OFF_RLD_H1    12'h0463
`define DTCM_OFF_PRESC     12'h0464
`define DTCM_OFF_IRQ_STAT  12'h0468
`define DTCM_OFF_IRQ_MASK  12'h0469
`define DTCM_OFF_ACK       12'h046A
`define DTCM_RST_BYTE      8'h00
`define DTCM_RST_PRESC     2'h0
`define DTCM_B_TF1         7
`define DTCM_B_TR1         6
`define DTCM_B_TF0         5
`define DTCM_B_TR0         4
`define DTCM_B_IE1         3
`define DTCM_B_IT1         2
`define DTCM_B_IE0         1
`define DTCM_B_IT0         0
`define DTCM_B_TOGGLE_OUT_ENABLE_ZERO        0
`define DTCM_B_T1OE        2
`define DTCM_M_AUTO16      2'h0
`define DTCM_M_FREE16      2'h1
`define DTCM_M_AUTO8       2'h2
`define DTCM_M_SPLIT       2'h3
`define DTCM_DIV4          8'h03
`define DTCM_DIV16         8'h0F
`define DTCM_DIV64         8'h3F
`endif

// ===== rtl/dtcm_top.v
/*
 dual 16-bit timer/counter with four modes, control/status register,
 external interrupt flags (edge or level per IT bit) and an avalon-mm register slave.
 assumes pins synchronous to i_clk (40 MHz) and an 8-bit register bus.
*/
// Chosen here: the Avalon-MM register port.
`include "dtcm_defines.vh"
module dtcm_top (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire [11:0] i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [7:0]  i_writedata,
  output reg  [7:0]  o_readdata,
  output reg         o_waitrequest,
  input  wire        i_count_in0,
  input  wire        i_count_in1,
  input  wire        i_ext_irq_n0,
  input  wire        i_ext_irq_n1,
  input  wire        i_vector_ack0,
  input  wire        i_vector_ack1,
  input  wire        i_ext_ack0,
  input  wire        i_ext_ack1,
  output reg         o_irq_timer0,
  output reg         o_irq_timer1,
  output reg         o_irq_ext0,
  output reg         o_irq_ext1,
  output reg         o_ovf_pulse1,
  output reg         o_irq
);
  reg  [7:0] timer_control_status;
  reg  [7:0] timer_mode_register;
  reg  [7:0] timer_extended_status;
  reg  [7:0] count_low_byte_zero;
  reg  [7:0] count_high_byte_zero;
  reg  [7:0] count_low_one;
  reg  [7:0] count_high_one;
  reg  [7:0] reload_low_zero;
  reg  [7:0] reload_high_zero;
  reg  [7:0] reload_low_one;
  reg  [7:0] reload_high_one;
  reg  [1:0] presc_sel;
  reg  [7:0] irq_stat;
  reg  [7:0] irq_mask;
  reg  [7:0] presc_cnt;
  reg        samp_phase;
  reg        cin0_q;
  reg        cin1_q;
  reg        xin0_q;
  reg        xin1_q;
  reg        ack_pend;
  reg  [7:0] div_lim;
  wire       tick;
  wire       sfall0;
  wire       sfall1;
  wire       xfall0;
  wire       xfall1;
  wire       wr;
  wire       rd;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire       ct0;
  wire       ct1;
  wire       gate0;
  wire       gate1;
  wire       en0;
  wire       en1;
  wire       enh0;
  wire       inc_l0;
  wire       inc_h0;
  wire       inc1;
  wire       split;
  wire       ovf0;
  wire       ovf1;
  wire       ovfh0;
  wire       set_tf0;
  wire       set_tf1;
  wire [16:0] sum0;
  wire [16:0] sum1;
  wire [8:0] sum_l0;
  wire [8:0] sum_h0;
  wire [8:0] sum_l1;
  reg  [7:0] next_readdata;

  // rule 18 fields: gate, c/t, m1, m0 per timer
  assign mode0 = timer_mode_register[1:0];
  assign ct0   = timer_mode_register[2];
  assign gate0 = timer_mode_register[3];
  assign mode1 = timer_mode_register[5:4];
  assign ct1   = timer_mode_register[6];
  assign gate1 = timer_mode_register[7];
  assign split = (mode0 == `DTCM_M_SPLIT);

  assign wr = i_write & ~o_waitrequest;
  assign rd = i_read & ~o_waitrequest;

  always @* begin
    case (presc_sel)
      2'h1:    div_lim = `DTCM_DIV16;
      2'h2:    div_lim = `DTCM_DIV64;
      default: div_lim = `DTCM_DIV4;
    endcase
  end

  assign tick = (presc_cnt == div_lim);
  always @(posedge i_clk) begin
    if (i_srst | tick)
      presc_cnt <= 8'h00;
    else
      presc_cnt <= presc_cnt + 8'h01;
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      samp_phase <= 1'b0;
      cin0_q     <= 1'b1;
      cin1_q     <= 1'b1;
      xin0_q     <= 1'b1;
      xin1_q     <= 1'b1;
    end else begin
      samp_phase <= ~samp_phase;
      if (samp_phase) begin
        cin0_q <= i_count_in0;
        cin1_q <= i_count_in1;
      end
      xin0_q <= i_ext_irq_n0;
      xin1_q <= i_ext_irq_n1;
    end
  end
  assign sfall0 = samp_phase & cin0_q & ~i_count_in0;
  assign sfall1 = samp_phase & cin1_q & ~i_count_in1;
  assign xfall0 = xin0_q & ~i_ext_irq_n0;
  assign xfall1 = xin1_q & ~i_ext_irq_n1;

  assign en0 = timer_control_status[`DTCM_B_TR0] & (~gate0 | i_ext_irq_n0);
  assign en1 = timer_control_status[`DTCM_B_TR1] & (~gate1 | i_ext_irq_n1);
  // low byte uses timer zero controls
  assign inc_l0 = en0 & (ct0 ? sfall0 : tick);
  // high byte internal, run bit one
  assign enh0   = timer_control_status[`DTCM_B_TR1];
  assign inc_h0 = split ? (enh0 & tick) : inc_l0;
  // timer one holds in mode 3
  assign inc1 = en1 & (mode1 != `DTCM_M_SPLIT) & (ct1 ? sfall1 : tick);

  assign sum0   = {1'b0, count_high_byte_zero, count_low_byte_zero} + 17'h1;
  assign sum1   = {1'b0, count_high_one, count_low_one} + 17'h1;
  assign sum_l0 = {1'b0, count_low_byte_zero} + 9'h001;
  assign sum_h0 = {1'b0, count_high_byte_zero} + 9'h001;
  assign sum_l1 = {1'b0, count_low_one} + 9'h001;

  assign ovf0 = inc_l0 & ((mode0[1] ? sum_l0[8] : sum0[16]));
  assign ovfh0 = split & inc_h0 & sum_h0[8];
  assign ovf1 = inc1 & (mode1[1] ? sum_l1[8] : sum1[16]);
  assign set_tf0 = ovf0 & ~timer_extended_status[`DTCM_B_TOGGLE_OUT_ENABLE_ZERO];
  // split high byte owns flag one
  assign set_tf1 = split ? (ovfh0 & ~timer_extended_status[`DTCM_B_T1OE])
                         : (ovf1 & ~timer_extended_status[`DTCM_B_T1OE]);

  // timer zero count
  always @(posedge i_clk) begin
    if (i_srst) begin
      count_low_byte_zero  <= `DTCM_RST_BYTE;
      count_high_byte_zero <= `DTCM_RST_BYTE;
    end else if (wr && i_address == `DTCM_OFF_CNT_L0) begin
      count_low_byte_zero <= i_writedata;
    end else if (wr && i_address == `DTCM_OFF_CNT_H0) begin
      count_high_byte_zero <= i_writedata;
    end else begin
      if (inc_l0) begin
        case (mode0)
          `DTCM_M_AUTO16: begin
            if (sum0[16]) begin
              count_low_byte_zero  <= reload_low_zero;
              count_high_byte_zero <= reload_high_zero;
            end else begin
              count_low_byte_zero  <= sum0[7:0];
              count_high_byte_zero <= sum0[15:8];
            end
          end
          `DTCM_M_FREE16: begin
            count_low_byte_zero  <= sum0[7:0];
            count_high_byte_zero <= sum0[15:8];
          end
          `DTCM_M_AUTO8: begin
            count_low_byte_zero <= sum_l0[8] ? reload_low_zero : sum_l0[7:0];
          end
          default: begin
            count_low_byte_zero <= sum_l0[7:0];
          end
        endcase
      end
      if (split && inc_h0)
        count_high_byte_zero <= sum_h0[7:0];
    end
  end

  // timer one count
  always @(posedge i_clk) begin
    if (i_srst) begin
      count_low_one  <= `DTCM_RST_BYTE;
      count_high_one <= `DTCM_RST_BYTE;
    end else if (wr && i_address == `DTCM_OFF_CNT_L1) begin
      count_low_one <= i_writedata;
    end else if (wr && i_address == `DTCM_OFF_CNT_H1) begin
      count_high_one <= i_writedata;
    end else if (inc1) begin
      case (mode1)
        `DTCM_M_AUTO16: begin
          if (sum1[16]) begin
            count_low_one  <= reload_low_one;
            count_high_one <= reload_high_one;
          end else begin
            count_low_one  <= sum1[7:0];
            count_high_one <= sum1[15:8];
          end
        end
        `DTCM_M_AUTO8: begin
          count_low_one <= sum_l1[8] ? reload_low_one : sum_l1[7:0];
        end
        default: begin
          count_low_one  <= sum1[7:0];
          count_high_one <= sum1[15:8];
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      reload_low_zero       <= `DTCM_RST_BYTE;
      reload_high_zero      <= `DTCM_RST_BYTE;
      reload_low_one        <= `DTCM_RST_BYTE;
      reload_high_one       <= `DTCM_RST_BYTE;
      timer_mode_register   <= `DTCM_RST_BYTE;
      timer_extended_status <= `DTCM_RST_BYTE;
      presc_sel             <= `DTCM_RST_PRESC;
      irq_mask              <= `DTCM_RST_BYTE;
    end else if (wr) begin
      case (i_address)
        `DTCM_OFF_RLD_L0:   reload_low_zero <= i_writedata;
        `DTCM_OFF_RLD_H0:   reload_high_zero <= i_writedata;
        `DTCM_OFF_RLD_L1:   reload_low_one <= i_writedata;
        `DTCM_OFF_RLD_H1:   reload_high_one <= i_writedata;
        `DTCM_OFF_MODE:     timer_mode_register <= i_writedata;
        `DTCM_OFF_XSTAT:    timer_extended_status <= i_writedata & 8'h05;
        `DTCM_OFF_PRESC:    presc_sel <= i_writedata[1:0];
        `DTCM_OFF_IRQ_MASK: irq_mask <= i_writedata & 8'h0F;
        default: begin
        end
      endcase
    end
  end

  // control/status: set wins over clear
  always @(posedge i_clk) begin
    if (i_srst) begin
      timer_control_status <= `DTCM_RST_BYTE;
    end else begin
      if (wr && i_address == `DTCM_OFF_CTRL)
        timer_control_status <= i_writedata;
      if (i_vector_ack0)
        timer_control_status[`DTCM_B_TF0] <= 1'b0;
      if (i_vector_ack1)
        timer_control_status[`DTCM_B_TF1] <= 1'b0;
      if (i_ext_ack0)
        timer_control_status[`DTCM_B_IE0] <= 1'b0;
      if (i_ext_ack1)
        timer_control_status[`DTCM_B_IE1] <= 1'b0;
      if (set_tf0)
        timer_control_status[`DTCM_B_TF0] <= 1'b1;
      if (set_tf1)
        timer_control_status[`DTCM_B_TF1] <= 1'b1;
      if (timer_control_status[`DTCM_B_IT0] ? xfall0 : ~i_ext_irq_n0)
        timer_control_status[`DTCM_B_IE0] <= 1'b1;
      if (timer_control_status[`DTCM_B_IT1] ? xfall1 : ~i_ext_irq_n1)
        timer_control_status[`DTCM_B_IE1] <= 1'b1;
    end
  end

  // sticky status, write one to clear, set wins
  always @(posedge i_clk) begin
    if (i_srst)
      irq_stat <= `DTCM_RST_BYTE;
    else
      irq_stat <= ((wr && i_address == `DTCM_OFF_IRQ_STAT) ?
                   (irq_stat & ~i_writedata) : irq_stat) |
                  {4'h0, xfall1, xfall0, set_tf1, set_tf0};
  end

  always @* begin
    case (i_address)
      `DTCM_OFF_CTRL:     next_readdata = timer_control_status;
      `DTCM_OFF_XSTAT:    next_readdata = timer_extended_status;
      `DTCM_OFF_CNT_L0:   next_readdata = count_low_byte_zero;
      `DTCM_OFF_CNT_H0:   next_readdata = count_high_byte_zero;
      `DTCM_OFF_CNT_L1:   next_readdata = count_low_one;
      `DTCM_OFF_CNT_H1:   next_readdata = count_high_one;
      `DTCM_OFF_MODE:     next_readdata = timer_mode_register;
      `DTCM_OFF_RLD_L0:   next_readdata = reload_low_zero;
      `DTCM_OFF_RLD_H0:   next_readdata = reload_high_zero;
      `DTCM_OFF_RLD_L1:   next_readdata = reload_low_one;
      `DTCM_OFF_RLD_H1:   next_readdata = reload_high_one;
      `DTCM_OFF_PRESC:    next_readdata = {6'h00, presc_sel};
      `DTCM_OFF_IRQ_STAT: next_readdata = irq_stat;
      `DTCM_OFF_IRQ_MASK: next_readdata = irq_mask;
      default:            next_readdata = 8'h00;
    endcase
  end

  // bus: one wait cycle per access, data at the accepting edge
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 8'h00;
      ack_pend      <= 1'b0;
    end else begin
      ack_pend      <= (i_read | i_write) & o_waitrequest & ~ack_pend;
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest & ~ack_pend);
      if ((i_read | i_write) & o_waitrequest & ~ack_pend)
        o_readdata <= next_readdata;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_irq_timer0 <= 1'b0;
      o_irq_timer1 <= 1'b0;
      o_irq_ext0   <= 1'b0;
      o_irq_ext1   <= 1'b0;
      o_ovf_pulse1 <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      o_irq_timer0 <= timer_control_status[`DTCM_B_TF0];
      o_irq_timer1 <= timer_control_status[`DTCM_B_TF1];
      o_irq_ext0   <= timer_control_status[`DTCM_B_IE0];
      o_irq_ext1   <= timer_control_status[`DTCM_B_IE1];
      // timer one overflow for serial port
      o_ovf_pulse1 <= ovf1;
      o_irq        <= |(irq_stat & irq_mask);
    end
  end
endmodule

// ===== test/dtcm_cpu_model.sv
/*
 cpu-side model: vectors to pending timer and external interrupts.
 assumes one-cycle acknowledges launched on the rising edge of i_clk.
*/
module dtcm_cpu_model (
  input  logic       i_clk,
  input  logic       i_en,
  input  logic [3:0] i_req,
  output logic [3:0] o_ack
);
  logic [3:0] ack_q;
  initial begin
    o_ack = 4'h0;
    ack_q = 4'h0;
  end
  always @(posedge i_clk) begin
    ack_q <= o_ack;
    o_ack <= {4{i_en}} & i_req & ~o_ack & ~ack_q;
  end
endmodule

// ===== test/dtcm_properties.sv
/*
 port checker for dtcm_top.
 assumes one clock domain and a synchronous active high reset.
*/
module dtcm_properties (
  input logic       i_clk,
  input logic       i_srst,
  input logic       i_read,
  input logic       i_write,
  input logic [7:0] o_readdata,
  input logic       o_waitrequest,
  input logic       i_vector_ack0,
  input logic       i_vector_ack1,
  input logic       i_ext_ack0,
  input logic       o_irq_timer0,
  input logic       o_irq_timer1,
  input logic       o_irq_ext0,
  input logic       o_ovf_pulse1,
  input logic       o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_reset_quiet: assert property ($fell(i_srst) |-> o_waitrequest &&
    !o_irq && !o_irq_timer0 && !o_irq_timer1) else $error("reset state");
  a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("wait low too long");
  a_wait_answer: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("no answer");
  a_idle_wait: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (o_waitrequest && $past(o_waitrequest)
    |-> $stable(o_readdata)) else $error("readdata moved");
  a_ack0_clears: assert property (
    i_vector_ack0 |-> ##2 !o_irq_timer0) else $error("flag0 kept");
  a_ack1_clears: assert property (
    i_vector_ack1 |-> ##2 !o_irq_timer1) else $error("flag1 kept");
  a_ext_ack_clears: assert property (
    i_ext_ack0 |-> ##2 !o_irq_ext0) else $error("edge flag kept");
  a_ovf_pulse_one: assert property (
    o_ovf_pulse1 |=> !o_ovf_pulse1) else $error("long pulse");
  cover property (i_read && !o_waitrequest);
  cover property ($rose(o_irq));
  cover property (o_ovf_pulse1);
endmodule
bind dtcm_top dtcm_properties i_dtcm_properties (.i_clk, .i_srst,
  .i_read, .i_write, .o_readdata, .o_waitrequest, .i_vector_ack0,
  .i_vector_ack1, .i_ext_ack0, .o_irq_timer0, .o_irq_timer1,
  .o_irq_ext0, .o_ovf_pulse1, .o_irq);

// ===== test/testbench.sv
/*
 testbench for dtcm_top: register bus, modes, flags and interrupts.
 assumes a 40 MHz clock and the cpu model beside the design.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 0, i_srst = 1, i_read = 0, i_write = 0, en = 0;
  logic [11:0] i_address = 12'h000;
  logic [7:0]  i_writedata = 8'h00, o_readdata, q;
  logic        o_waitrequest, o_ovf_pulse1, o_irq;
  logic        cin0 = 1, cin1 = 1, xn0 = 1, xn1 = 1;
  logic [3:0]  irq, ack;
  wire  [4:0]  w = {o_ovf_pulse1, irq};
  int          mismatches = 0, n_tests = 0, n;
  always #12.5 i_clk = ~i_clk;
  dtcm_top i_dtcm_top (.i_clk, .i_srst, .i_address, .i_read, .i_write,
    .i_writedata, .o_readdata, .o_waitrequest, .i_count_in0(cin0),
    .i_count_in1(cin1), .i_ext_irq_n0(xn0), .i_ext_irq_n1(xn1),
    .i_vector_ack0(ack[0]), .i_vector_ack1(ack[1]), .i_ext_ack0(ack[2]),
    .i_ext_ack1(ack[3]), .o_irq_timer0(irq[0]), .o_irq_timer1(irq[1]),
    .o_irq_ext0(irq[2]), .o_irq_ext1(irq[3]), .o_ovf_pulse1, .o_irq);
  dtcm_cpu_model i_dtcm_cpu_model (.i_clk, .i_en(en), .i_req(irq),
    .o_ack(ack));
  task end_sim;
    $display("mismatches %0d tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(string s, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task tmo;
    if (n >= 200) begin
      mismatches++;
      end_sim;
    end
  endtask
  task acc(bit wr_n, logic [11:0] a, logic [7:0] d);
    int k;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    if (wr_n) i_write <= 1;
    else i_read <= 1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_clk);
      if (o_waitrequest === 1'b0) break;
    end
    n = k;
    q = o_readdata;
    i_write <= 0;
    i_read <= 0;
    tmo;
  endtask
  task wr(logic [11:0] a, logic [7:0] d);
    acc(1, a, d);
  endtask
  task rd(string s, logic [11:0] a, logic [7:0] e);
    acc(0, a, 8'h00);
    chk(s, e, q);
  endtask
  task wt(int i, logic v);
    for (n = 0; n < 200 && w[i] !== v; n++) @(posedge i_clk);
    tmo;
  endtask
  task t_mode(logic [1:0] m, logic [7:0] h, logic [7:0] eh);
    wr(12'h460, 8'hFE);
    wr(12'h461, 8'hFF);
    wr(12'h450, 8'hFE);
    wr(12'h451, h);
    wr(12'h45C, {6'h00, m});
    wr(12'h410, 8'h10);
    wt(0, 1);
    wr(12'h410, 8'h20);
    rd("high0", 12'h451, eh);
    rd("ctrl", 12'h410, 8'h20);
    en <= 1;
    wt(0, 0);
    en <= 0;
    rd("ctrl", 12'h410, 8'h00);
  endtask
  task t_toggle;
    wr(12'h411, 8'h01);
    wr(12'h450, 8'hFE);
    wr(12'h451, 8'hFF);
    wr(12'h45C, 8'h01);
    wr(12'h410, 8'h10);
    repeat (40) @(posedge i_clk);
    wr(12'h410, 8'h00);
    rd("ctrl", 12'h410, 8'h00);
    rd("high0", 12'h451, 8'h00);
    wr(12'h411, 8'h00);
  endtask
  task t_split;
    wr(12'h45C, 8'h33);
    wr(12'h450, 8'h00);
    wr(12'h451, 8'hFE);
    wr(12'h453, 8'h77);
    wr(12'h410, 8'h40);
    wt(1, 1);
    wr(12'h410, 8'h80);
    rd("low0", 12'h450, 8'h00);
    rd("high1", 12'h453, 8'h77);
    en <= 1;
    wt(1, 0);
    en <= 0;
    wr(12'h45C, 8'h13);
    wr(12'h452, 8'hFE);
    wr(12'h453, 8'hFF);
    wr(12'h410, 8'h40);
    wt(4, 1);
    wr(12'h410, 8'h00);
    repeat (2) @(posedge i_clk);
    chk("irq1", 8'h00, irq[1]);
  endtask
  task t_irq;
    wr(12'h469, 8'h02);
    repeat (2) @(posedge i_clk);
    chk("irq", 8'h01, o_irq);
    wr(12'h469, 8'hFF);
    rd("mask", 12'h469, 8'h0F);
    wr(12'h468, 8'h0F);
    rd("stat", 12'h468, 8'h00);
    repeat (2) @(posedge i_clk);
    chk("irq", 8'h00, o_irq);
  endtask
  task t_ext;
    wr(12'h410, 8'h01);
    xn0 <= 0;
    xn1 <= 0;
    wt(2, 1);
    wt(3, 1);
    chk("irq", 8'h01, o_irq);
    xn1 <= 1;
    en <= 1;
    wt(2, 0);
    wt(3, 0);
    en <= 0;
    repeat (8) @(posedge i_clk);
    chk("ext0", 8'h00, irq[2]);
    xn0 <= 1;
    rd("ctrl", 12'h410, 8'h01);
  endtask
  task t_count;
    wr(12'h45C, 8'h50);
    wr(12'h452, 8'h00);
    wr(12'h453, 8'h00);
    wr(12'h410, 8'h40);
    repeat (3) begin
      cin1 <= 0;
      repeat (4) @(posedge i_clk);
      cin1 <= 1;
      repeat (4) @(posedge i_clk);
    end
    wr(12'h410, 8'h00);
    rd("low1", 12'h452, 8'h03);
  endtask
  task t_presc;
    int c;
    wr(12'h464, 8'h01);
    wr(12'h45C, 8'h20);
    wr(12'h462, 8'hFC);
    wr(12'h452, 8'hFC);
    wr(12'h410, 8'h40);
    wt(4, 1);
    @(posedge i_clk);
    for (c = 1; c < 200 && w[4] !== 1'b1; c++) @(posedge i_clk);
    chk("period", 8'h40, c[7:0]);
    wr(12'h410, 8'h00);
    wr(12'h464, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst <= 0;
    rd("ctrl", 12'h410, 8'h00);
    rd("unmapped", 12'h46A, 8'h00);
    t_mode(2'h0, 8'hFF, 8'hFF);
    t_mode(2'h1, 8'hFF, 8'h00);
    t_mode(2'h2, 8'h5A, 8'h5A);
    t_toggle;
    t_split;
    t_irq;
    t_ext;
    t_count;
    t_presc;
    end_sim;
  end
endmodule
